// [hdl/ivob_top.sv]
// Notes on behaviour
// R1: Offset registers hold only bits 17:1; other bits ignore writes, read zero.
// R2: Reset clears every offset register to zero.
// R3: Flag and enable registers decode clear, set, invert aliases at +4, +8, +C.
// R4: Offset registers have no aliases; only their own address changes them.
// R5: A flag sets when its source is enabled and its event occurs.
// R6: Flag setting ignores the interrupt enable, so software may poll.
// R7: Flags stay set until software clears them; software must clear them.
// R8: Without the CAN module its flag and enable bits are absent, read zero.
// R9: Handler address is vector base plus the chosen vector's offset.
`timescale 1ns/1ns
`default_nettype none
module ivob_top
  import ivob_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1
)(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [ivob_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                          awvalid,
  output var  logic                          awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output var  logic                          wready,
  output var  logic [1:0]                    bresp,
  output var  logic                          bvalid,
  input  wire logic                          bready,
  input  wire logic [ivob_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                          arvalid,
  output var  logic                          arready,
  output var  logic [31:0]                   rdata,
  output var  logic [1:0]                    rresp,
  output var  logic                          rvalid,
  input  wire logic                          rready,
  input  wire logic [ivob_pkg::NUM_VEC-1:0]  src_enable,
  input  wire logic [ivob_pkg::NUM_VEC-1:0]  src_event,
  input  wire logic                          take_valid,
  input  wire logic [ivob_pkg::IDX_W-1:0]    take_idx,
  input  wire logic [31:0]                   vec_base,
  output var  logic [31:0]                   handler_addr,
  output var  logic                          handler_valid,
  output var  logic                          irq
);
  import ivob_pkg::*;

  logic [NUM_VEC-1:0][OFF_W-1:0] off_q;
  logic [NUM_VEC-1:0]            flag_q;
  logic [NUM_VEC-1:0]            ena_q;
  logic [NUM_VEC-1:0]            impl;
  logic [NUM_VEC-1:0]            hw_set;
  logic [ADDR_W-1:0]             aw_addr_q;
  logic [31:0]                   w_data_q;
  logic [3:0]                    w_strb_q;
  logic                          aw_full_q;
  logic                          w_full_q;
  logic                          aw_full_d;
  logic                          w_full_d;
  logic                          bvalid_d;
  logic                          rvalid_d;
  logic                          awready_q;
  logic                          wready_q;
  logic                          bvalid_q;
  logic [1:0]                    bresp_q;
  logic                          arready_q;
  logic                          rvalid_q;
  logic [31:0]                   rdata_q;
  logic [1:0]                    rresp_q;
  logic                          rd_vec_q;
  logic                          wr_fire;
  logic                          rd_fire;
  logic [IDX_W:0]                wr_lk;
  logic [IDX_W:0]                rd_lk;
  logic [31:0]                   wbits;
  logic [31:0]                   wmask;
  logic [31:0]                   wmerge;
  logic                          wr_err;
  logic [NUM_VEC-1:0]            f_clr;
  logic [NUM_VEC-1:0]            f_set;
  logic [NUM_VEC-1:0]            f_inv;
  logic [NUM_VEC-1:0]            e_clr;
  logic [NUM_VEC-1:0]            e_set;
  logic [NUM_VEC-1:0]            e_inv;
  logic                          e_wr;
  logic [31:0]                   hdl_q;
  logic                          hvalid_q;
  logic                          irq_q;

  assign awready       = awready_q;
  assign wready        = wready_q;
  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign arready       = arready_q;
  assign rvalid        = rvalid_q;
  assign rdata         = rdata_q;
  assign rresp         = rresp_q;
  assign handler_addr  = hdl_q;
  assign handler_valid = hvalid_q;
  assign irq           = irq_q;

  assign impl    = HAS_CAN ? {NUM_VEC{1'b1}} : ~CAN_BITS; // R8
  assign hw_set  = src_enable & src_event & impl; // R5 R6
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign rd_fire = arvalid & arready_q;
  assign wr_lk   = vec_lookup(aw_addr_q);
  assign rd_lk   = vec_lookup(araddr);
  assign wbits   = w_data_q & strb_mask(w_strb_q);
  assign wmask   = strb_mask(w_strb_q);

  // Write and read channel sequencing
  always_comb
  begin
    aw_full_d = (aw_full_q | (awvalid & awready_q)) & ~wr_fire;
    w_full_d  = (w_full_q | (wvalid & wready_q)) & ~wr_fire;
    bvalid_d  = wr_fire | (bvalid_q & ~bready);
    rvalid_d  = rd_fire | (rvalid_q & ~rready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= DATA_ZERO;
      w_strb_q  <= '0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (awvalid && awready_q)
      begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready_q)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        bresp_q <= wr_err ? RESP_SLVE : RESP_OKAY;
      end
    end
  end

  // Write address decode
  always_comb
  begin
    f_clr  = '0;
    f_set  = '0;
    f_inv  = '0;
    e_clr  = '0;
    e_set  = '0;
    e_inv  = '0;
    e_wr   = 1'b0;
    wr_err = 1'b0;
    wmerge = (DATA_ZERO | (32'(off_q[wr_lk[IDX_W-1:0]]) << OFF_LSB));
    wmerge = (wmerge & ~strb_mask(w_strb_q)) | wbits;
    if (wr_lk[IDX_W])
    begin
      wr_err = 1'b0; // R4
    end
    else if (aw_addr_q == FLAG_BASE)
    begin
      f_clr = wbits[NUM_VEC-1:0];
    end
    else if (aw_addr_q == (FLAG_BASE | ALIAS_CLR))
    begin
      f_clr = wbits[NUM_VEC-1:0]; // R3
    end
    else if (aw_addr_q == (FLAG_BASE | ALIAS_SET))
    begin
      f_set = wbits[NUM_VEC-1:0]; // R3
    end
    else if (aw_addr_q == (FLAG_BASE | ALIAS_INV))
    begin
      f_inv = wbits[NUM_VEC-1:0]; // R3
    end
    else if (aw_addr_q == ENA_BASE)
    begin
      e_wr = 1'b1;
    end
    else if (aw_addr_q == (ENA_BASE | ALIAS_CLR))
    begin
      e_clr = wbits[NUM_VEC-1:0]; // R3
    end
    else if (aw_addr_q == (ENA_BASE | ALIAS_SET))
    begin
      e_set = wbits[NUM_VEC-1:0]; // R3
    end
    else if (aw_addr_q == (ENA_BASE | ALIAS_INV))
    begin
      e_inv = wbits[NUM_VEC-1:0]; // R3
    end
    else
    begin
      wr_err = 1'b1;
    end
  end

  // Offset bank
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_VEC; i++)
      begin
        off_q[i] <= OFF_RST; // R2
      end
    end
    else if (wr_fire && wr_lk[IDX_W])
    begin
      off_q[wr_lk[IDX_W-1:0]] <= wmerge[OFF_MSB:OFF_LSB]; // R1 R4
    end
  end

  // Flags: a hardware event beats a software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_q <= FLAG_RST;
    end
    else if (wr_fire)
    begin
      flag_q <= ((((flag_q & ~f_clr) | f_set) ^ f_inv) | hw_set) & impl; // R3 R7
    end
    else
    begin
      flag_q <= (flag_q | hw_set) & impl; // R5 R7
    end
  end

  // Interrupt enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ena_q <= FLAG_RST;
    end
    else if (wr_fire && e_wr)
    begin
      ena_q <= ((ena_q & ~wmask[NUM_VEC-1:0]) | wbits[NUM_VEC-1:0]) & impl; // R8
    end
    else if (wr_fire)
    begin
      ena_q <= (((ena_q & ~e_clr) | e_set) ^ e_inv) & impl; // R3
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(flag_q & ena_q);
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= DATA_ZERO;
      rresp_q   <= RESP_OKAY;
      rd_vec_q  <= 1'b0;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (rd_fire)
      begin
        rresp_q  <= RESP_OKAY;
        rd_vec_q <= rd_lk[IDX_W];
        if (rd_lk[IDX_W])
        begin
          rdata_q <= DATA_ZERO | (32'(off_q[rd_lk[IDX_W-1:0]]) << OFF_LSB); // R1
        end
        else if (araddr == FLAG_BASE)
        begin
          rdata_q <= DATA_ZERO | 32'(flag_q);
        end
        else if (araddr == ENA_BASE)
        begin
          rdata_q <= DATA_ZERO | 32'(ena_q);
        end
        else
        begin
          rdata_q <= DATA_ZERO;
          rresp_q <= RESP_SLVE;
        end
      end
    end
  end

  // Handler address on vector take
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hdl_q    <= DATA_ZERO;
      hvalid_q <= 1'b0;
    end
    else
    begin
      hvalid_q <= take_valid;
      if (take_valid)
      begin
        hdl_q <= vec_base + (32'(off_q[take_idx]) << OFF_LSB); // R9
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_OFF_RSVD: assert property (rvalid && rd_vec_q |-> rdata[31:OFF_MSB+1] == '0 && !rdata[0]) // R1
    else $error("offset read shows a reserved bit");

  AST_RESET_ZERO: assert property (disable iff (1'b0) !aresetn |=> off_q == '0) // R2
    else $error("offset bank not cleared by reset");

  AST_ALIAS_CLR: assert property (wr_fire && aw_addr_q == (ENA_BASE | ALIAS_CLR)
      |=> (ena_q & $past(wbits[NUM_VEC-1:0])) == '0) // R3
    else $error("clear alias left an enable bit set");

  AST_ALIAS_INV: assert property (wr_fire && aw_addr_q == (ENA_BASE | ALIAS_INV)
      |=> ena_q == (($past(ena_q) ^ $past(wbits[NUM_VEC-1:0])) & impl)) // R3
    else $error("invert alias wrong");

  AST_NO_ALIAS: assert property (!(wr_fire && wr_lk[IDX_W]) |=> $stable(off_q)) // R4
    else $error("offset changed without a direct write");

  AST_FLAG_SET: assert property (hw_set != '0 ##1 ena_q == '0
      |-> (flag_q & $past(hw_set)) == $past(hw_set)) // R5 R6
    else $error("event did not set its flag");

  AST_STICKY: assert property (!(wr_fire && (f_clr | f_inv) != '0)
      |=> ($past(flag_q) & ~flag_q) == '0) // R7
    else $error("flag fell without a clear");

  AST_CAN_ABSENT: assert property (((flag_q | ena_q) & ~impl) == '0) // R8
    else $error("absent bit is set");

  AST_HANDLER: assert property (take_valid |=> handler_valid
      && handler_addr == $past(vec_base) + (32'($past(off_q[take_idx])) << OFF_LSB)) // R9
    else $error("handler address wrong");

  AST_IRQ: assert property ((flag_q & ena_q) != '0 ##1 (flag_q & ena_q) != '0 |-> irq)
    else $error("interrupt output missing");

  AST_IRQ_LOW: assert property ((flag_q & ena_q) == '0 |=> !irq)
    else $error("interrupt output high with nothing pending");

  COV_VEC_WRITE: cover property (wr_fire && wr_lk[IDX_W] ##1 bvalid);
  COV_FLAG_CLR:  cover property (flag_q != '0 ##1 wr_fire && f_clr != '0 ##1 flag_q == '0);
  COV_IRQ:       cover property ($rose(irq));
  COV_TAKE:      cover property (take_valid && off_q[take_idx] != '0);
endmodule
`default_nettype wire

// [inc/ivob_pkg.sv]
`default_nettype none
package ivob_pkg;
  localparam int          NUM_VEC   = 15;
  localparam int          IDX_W     = 4;
  localparam int          ADDR_W    = 12;
  localparam int          OFF_W     = 17;
  localparam int          OFF_LSB   = 1;
  localparam int          OFF_MSB   = 17;
  localparam logic [16:0] OFF_RST   = 17'h0_0000;
  localparam logic [14:0] FLAG_RST  = 15'h0000;
  localparam logic [14:0] CAN_BITS  = 15'h7C00;
  localparam logic [11:0] FLAG_BASE = 12'h700;
  localparam logic [11:0] ENA_BASE  = 12'h710;
  localparam logic [11:0] ALIAS_CLR = 12'h004;
  localparam logic [11:0] ALIAS_SET = 12'h008;
  localparam logic [11:0] ALIAS_INV = 12'h00C;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVE = 2'h2;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // Vectors 57..61 then 71..80
  localparam logic [11:0] VEC_ADDR [NUM_VEC] = '{
    12'h624, 12'h628, 12'h62C, 12'h630, 12'h634,
    12'h65C, 12'h660, 12'h664, 12'h668, 12'h66C,
    12'h670, 12'h674, 12'h678, 12'h67C, 12'h680};

  // Bit 4 is the hit, bits 3:0 the vector index
  function automatic logic [IDX_W:0] vec_lookup(input logic [ADDR_W-1:0] a);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < NUM_VEC; i++)
    begin
      if (a == VEC_ADDR[i])
      begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
endpackage
`default_nettype wire

// [test/ivob_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ivob_core_model
  import ivob_pkg::*;
(
  input  wire logic                        aclk,
  output var  logic                        take_valid,
  output var  logic [ivob_pkg::IDX_W-1:0]  take_idx
);
  initial
  begin
    take_valid = 1'b0;
    take_idx   = '0;
  end

  // One-cycle vector take, index scrambled once released
  task automatic take(input logic [IDX_W-1:0] i);
    take_valid <= 1'b1;
    take_idx   <= i;
    @(posedge aclk);
    take_valid <= 1'b0;
    take_idx   <= ~i;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ivob_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, take_valid, handler_valid, irq;
  logic [11:0] awaddr, araddr, base;
  logic [31:0] wdata, rdata, vec_base, handler_addr, seed, got;
  logic [3:0]  wstrb, take_idx, strb;
  logic [1:0]  bresp, rresp;
  logic [14:0] src_enable, src_event, exp_v;
  logic [31:0] offs [NUM_VEC];
  int          ops [3] = '{2, 1, 3};
  int          n_fail, cmp_count, cyc;
  // Device without the CAN sources: flag and enable bits of vectors 76..80 must stay absent
  localparam bit          HAS_CAN = 1'b0;
  localparam logic [14:0] IMPL_V  = HAS_CAN ? 15'h7FFF : ~CAN_BITS;

  ivob_top #(
    .HAS_CAN(HAS_CAN)
  ) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .src_enable, .src_event, .take_valid, .take_idx, .vec_base,
    .handler_addr, .handler_valid, .irq);
  ivob_core_model u_core (.aclk, .take_valid, .take_idx);

  always #10 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
  endfunction

  // Only the offset field, bits 17:1, survives a write
  function automatic logic [31:0] exp_off(input logic [31:0] d);
    return d & 32'h0003_FFFE;
  endfunction

  task automatic conclude;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    got = rdata;
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  // Cuts a hang short
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    logic [3:0]  idx;
    logic [31:0] d;
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, vec_base} = '0;
    {src_enable, src_event} = '0;
    seed = 32'h57B4;
    strb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, then field masking with random and all-ones data
    for (int i = 0; i < NUM_VEC; i++)
    begin
      rd(VEC_ADDR[i], RESP_OKAY);
      chk(got, DATA_ZERO);
      seed = lfsr(seed);
      offs[i] = (i == 14) ? 32'hFFFF_FFFF : seed;
      wr(VEC_ADDR[i], offs[i], RESP_OKAY);
    end
    wr(12'h684, 32'hFFFF_FFFF, RESP_SLVE);
    for (int i = 0; i < NUM_VEC; i++)
    begin
      rd(VEC_ADDR[i], RESP_OKAY);
      chk(got, exp_off(offs[i]));
    end
    // Byte strobe: only the low byte of the first offset takes new data
    strb = 4'h1;
    wr(VEC_ADDR[0], 32'hFFFF_FFFF, RESP_OKAY);
    strb = 4'hF;
    offs[0] = offs[0] | 32'h0000_00FF;
    rd(VEC_ADDR[0], RESP_OKAY);
    chk(got, exp_off(offs[0]));
    // Vector takes
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      idx = 4'(seed % 15);
      vec_base <= seed;
      u_core.take(idx);
      @(negedge aclk);
      chk({31'h0, handler_valid}, 32'h1);
      chk(handler_addr, vec_base + exp_off(offs[idx]));
      @(posedge aclk);
    end
    // Events with the mask clear, then masked irq, then clear
    seed = lfsr(seed);
    src_enable <= seed[14:0] | 15'h1;
    src_event <= seed[30:16] | 15'h1;
    exp_v = (seed[14:0] | 15'h1) & (seed[30:16] | 15'h1) & IMPL_V;
    @(posedge aclk);
    src_event <= '0;
    repeat (3) @(posedge aclk);
    rd(FLAG_BASE, RESP_OKAY);
    chk(got, {17'h0, exp_v});
    chk({31'h0, irq}, 32'h0);
    wr(ENA_BASE, {17'h0, exp_v}, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(FLAG_BASE, RESP_OKAY);
    chk(got, {17'h0, exp_v});
    wr(FLAG_BASE, {17'h0, exp_v}, RESP_OKAY);
    rd(FLAG_BASE, RESP_OKAY);
    chk(got, DATA_ZERO);
    chk({31'h0, irq}, 32'h0);
    // Set, clear, invert aliases on both registers
    src_enable <= '0;
    wr(ENA_BASE, DATA_ZERO, RESP_OKAY);
    for (int b = 0; b < 2; b++)
    begin
      base = b ? ENA_BASE : FLAG_BASE;
      exp_v = '0;
      for (int op = 0; op < 3; op++)
      begin
        seed = lfsr(seed);
        d = {17'h0, seed[14:0]};
        wr(base + 12'(4 * ops[op]), d, RESP_OKAY);
        exp_v = ops[op] == 1 ? exp_v & ~d[14:0] : ops[op] == 2 ? exp_v | d[14:0] : exp_v ^ d[14:0];
        exp_v = exp_v & IMPL_V;
        rd(base, RESP_OKAY);
        chk(got, {17'h0, exp_v});
      end
    end
    wr(ENA_BASE + ALIAS_SET, 32'hFFFF_FFFF, RESP_OKAY);
    rd(ENA_BASE, RESP_OKAY);
    chk(got, {17'h0, IMPL_V});
    rd(FLAG_BASE + ALIAS_CLR, RESP_SLVE);
    rd(12'h7F0, RESP_SLVE);
    // Reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(VEC_ADDR[14], RESP_OKAY);
    chk(got, DATA_ZERO);
    conclude();
  end
endmodule
`default_nettype wire
